/* File: ecc_pkg.sv */
package ecc_pkg;
	localparam logic [3:0] ADDR_TX = 4'h0;
	localparam logic [3:0] ADDR_LINE = 4'h4;
	localparam logic [3:0] ADDR_AC = 4'h8;
	localparam logic [3:0] ADDR_STAT = 4'hc;
	localparam logic [5:0] RST_TX = 6'h00;
	localparam logic [7:0] RST_CH = 8'h00;
	localparam logic [7:0] CH_MASK = 8'hbf;
	localparam int BIT_BYP = 7;
	localparam int BIT_FRZ = 5;
	localparam int BIT_HOWL = 4;
	localparam int BIT_CLIP = 3;
	localparam int BIT_PAD = 2;
	localparam int BIT_ATT = 1;
	localparam int BIT_GC = 0;
	localparam logic [5:0] CODE_MUTE = 6'h2b;
	localparam logic signed [7:0] GAIN_STEP_DB = 8'sh03;
	localparam logic signed [7:0] GAIN_MAX_CODE = 8'sh0a;
	localparam logic signed [7:0] GAIN_MIN_CODE = -8'sh14;
	localparam logic signed [7:0] GAIN_MAX_DB = 8'sh1e;
	localparam logic signed [7:0] GAIN_MIN_DB = -8'sh3c;
	localparam logic [4:0] PAD_STEP_DB = 5'h06;
	localparam logic [3:0] ATT_DB_SHALLOW = 4'h6;
	localparam logic [3:0] ATT_DB_DEEP = 4'hc;
	localparam int SAMPLE_W = 16;
	localparam logic [15:0] CLIP_THRESH = 16'h0020;
	localparam logic [15:0] CLIP_MIN = 16'h0001;
	localparam int HOLD_US = 250;
	localparam int CLK_MHZ = 250;
	localparam int HOLD_CYC = HOLD_US * CLK_MHZ;
	localparam int PIN_W = 15;
endpackage

/* File: ecc_ctl_if.sv */
`timescale 1ns/1ps
interface ecc_ctl_if;
	logic bypass;
	logic freeze;
	logic howl_off;
	logic clip;
	logic atten_off;
	logic atten_deep;
	logic gc_off;
	logic rx_act;
	logic tx_act;
	modport src(output bypass, freeze, howl_off, clip, atten_off, atten_deep, gc_off, rx_act,
		tx_act);
	modport chan(input bypass, freeze, howl_off, clip, atten_off, atten_deep, gc_off, rx_act,
		tx_act);
endinterface

/* File: ecc_sync.sv */
`timescale 1ns/1ps
module ecc_sync #(
	parameter int W = ecc_pkg::PIN_W
) (
	input wire logic mclk, // clock
	input wire logic sys_rst, // async reset
	input wire logic [W-1:0] din, // asynchronous pins
	output logic [W-1:0] dout // synchronised
);
	import ecc_pkg::*;
	logic [W-1:0] meta_q;
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			meta_q <= '0;
			dout <= '0;
		end
		else
		begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule

/* File: ecc_chan.sv */
`timescale 1ns/1ps
module ecc_chan #(
	parameter int W = ecc_pkg::SAMPLE_W,
	parameter logic [W-1:0] THR = ecc_pkg::CLIP_THRESH
) (
	input wire logic mclk, // clock
	input wire logic sys_rst, // async reset
	ecc_ctl_if.chan ctl, // latched controls and unlatched path activity
	input wire logic [W-1:0] rx_in, // receive input sample
	input wire logic [W-1:0] tx_in, // send input sample
	input wire logic [W-1:0] core_rx, // canceler receive result
	input wire logic [W-1:0] core_tx, // canceler send result
	output logic [W-1:0] rx_out, // receive output
	output logic [W-1:0] tx_out, // send output
	output logic coef_freeze, // hold filter coefficients
	output logic howl_en, // howling detector on
	output logic send_att, // send attenuator on
	output logic recv_att, // receive attenuator on
	output logic [3:0] att_db, // attenuator depth
	output logic gc_en // input gain controller on
);
	import ecc_pkg::*;
	logic quiet;
	logic att_on;
	// small samples, both polarities, count as below the clip level
	assign quiet = ($signed(core_tx) <= $signed(THR)) && ($signed(core_tx) >= -$signed(THR));
	assign att_on = !ctl.bypass && !ctl.atten_off;

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rx_out <= '0;
			tx_out <= '0;
		end
		else
		begin
			rx_out <= ctl.bypass ? rx_in : core_rx; // RULE4 RULE5
			if (ctl.bypass)
				tx_out <= tx_in; // RULE4 RULE5
			else if (ctl.clip && quiet)
				tx_out <= W'(CLIP_MIN); // RULE9
			else
				tx_out <= core_tx;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			coef_freeze <= 1'b0;
			howl_en <= 1'b0;
			send_att <= 1'b0;
			recv_att <= 1'b0;
			att_db <= ATT_DB_SHALLOW;
			gc_en <= 1'b0;
		end
		else
		begin
			// bypass keeps coefficients, so it freezes adaptation too
			coef_freeze <= ctl.bypass || ctl.freeze; // RULE4 RULE7
			howl_en <= !ctl.bypass && !ctl.howl_off; // RULE6 RULE8
			send_att <= att_on && ctl.rx_act && !ctl.tx_act; // RULE11 RULE12
			recv_att <= att_on && ctl.tx_act; // RULE11 RULE12
			att_db <= ctl.atten_deep ? ATT_DB_DEEP : ATT_DB_SHALLOW; // RULE12
			gc_en <= !ctl.bypass && !ctl.gc_off; // RULE6 RULE13
		end
	end

	property p_byp_pass;
		@(posedge mclk) disable iff (sys_rst)
		ctl.bypass |=> (tx_out == $past(tx_in)) && (rx_out == $past(rx_in));
	endproperty
	a_byp_pass: assert property (p_byp_pass) // RULE4
		else $error("bypass did not pass samples through");

	property p_clip;
		@(posedge mclk) disable iff (sys_rst)
		(!ctl.bypass && ctl.clip && quiet) |=> tx_out == W'(CLIP_MIN);
	endproperty
	a_clip: assert property (p_clip) // RULE9
		else $error("center clip did not force minimum positive value");
endmodule

/* File: ecc_regs.sv */
`timescale 1ns/1ps
// Operation
// RULE1: six-bit transmit gain, 3 dB steps, mute code
// RULE2: latch controls on frame sync rising edge
// RULE3: host grounds gain pins when register used
// RULE4: line bypass passes samples, keeps coefficients
// RULE5: acoustic bypass is bit OR pin
// RULE6: bypass disables howl, hold, attenuator, gain control; code forces coefficient hold on in bypass
// RULE7: bit five freezes adaptive coefficients
// RULE8: bit four clear enables howling detector
// RULE9: center clip forces smallest positive sample
// RULE10: noise pad code from both bit twos
// RULE11: line attenuator side follows path activity
// RULE12: acoustic attenuator depth twelve or six dB
// RULE13: bit zero clear enables input gain controller
// RULE14: host keeps reserved bits at zero
// RULE15: active-low pins inverted before the OR
module ecc_regs #(
	parameter int HOLD_CYC = ecc_pkg::HOLD_CYC,
	parameter logic [15:0] CLIP_THR = ecc_pkg::CLIP_THRESH
) (
	input wire logic mclk, // clock
	input wire logic sys_rst, // async reset
	input wire logic [3:0] avs_address, // byte address
	input wire logic avs_read, // read request
	input wire logic avs_write, // write request
	input wire logic [31:0] avs_writedata, // write data
	input wire logic [3:0] avs_byteenable, // byte lanes
	output logic [31:0] avs_readdata, // read data
	output logic avs_waitrequest, // stall
	input wire logic frame_sync, // 8 kHz frame sync pin
	input wire logic line_bypass, // pin, high bypasses
	input wire logic acoustic_bypass, // pin, high bypasses
	input wire logic line_howl_detect_off_n, // pin, low disables
	input wire logic acoustic_howl_detect_off_n, // pin, low disables
	input wire logic noise_pad_low_bit, // pin
	input wire logic noise_pad_high_bit, // pin
	input wire logic line_atten_off, // pin, high disables
	input wire logic acoustic_atten_depth_n, // pin, low gives deep
	input wire logic line_gain_ctrl_off_n, // pin, low disables
	input wire logic acoustic_gain_ctrl_off_n, // pin, low disables
	input wire logic [3:0] transmit_gain_pin, // gain pins
	input wire logic line_rx_active, // line receive carries input
	input wire logic line_tx_active, // line send carries input
	input wire logic ac_rx_active, // acoustic receive carries input
	input wire logic ac_tx_active, // acoustic send carries input
	input wire logic [15:0] line_receive_in, // sample
	input wire logic [15:0] line_send_in, // sample
	input wire logic [15:0] acoustic_receive_in, // sample
	input wire logic [15:0] acoustic_send_in, // sample
	input wire logic [15:0] line_core_rx, // line canceler result
	input wire logic [15:0] line_core_tx, // line canceler result
	input wire logic [15:0] ac_core_rx, // acoustic canceler result
	input wire logic [15:0] ac_core_tx, // acoustic canceler result
	output logic [15:0] line_receive_out, // sample
	output logic [15:0] line_send_out, // sample
	output logic [15:0] acoustic_receive_out, // sample
	output logic [15:0] acoustic_send_out, // sample
	output logic signed [7:0] tx_gain_db, // transmit gain in dB
	output logic tx_mute, // transmit muted
	output logic line_coef_freeze, // hold line coefficients
	output logic acoustic_coef_freeze, // hold acoustic coefficients
	output logic line_howl_en, // line howling detector
	output logic ac_howl_en, // acoustic howling detector
	output logic line_send_attenuator, // on
	output logic line_receive_attenuator, // on
	output logic acoustic_send_attenuator, // on
	output logic acoustic_receive_attenuator, // on
	output logic [3:0] ac_atten_db, // acoustic depth in dB
	output logic line_input_gain_controller, // on
	output logic acoustic_input_gain_controller, // on
	output logic [4:0] noise_output_gain, // dB
	output logic signed [5:0] noise_input_loss // dB, negative
);
	import ecc_pkg::*;

	logic [PIN_W-1:0] pins_s;
	logic fs_s;
	logic fs_prev_q;
	logic fs_rise;
	logic [5:0] tx_reg_q;
	logic [7:0] line_reg_q;
	logic [7:0] ac_reg_q;
	logic [5:0] tx_eff_q;
	logic [7:0] line_eff_q;
	logic [7:0] ac_eff_q;
	logic [5:0] tx_eff_d;
	logic [7:0] line_eff_d;
	logic [7:0] ac_eff_d;
	logic [16:0] hold_q;
	logic req;
	logic take;
	logic lane0;
	logic [1:0] pad_code;
	logic [4:0] pad_db;
	logic [3:0] ac_db;

	ecc_ctl_if line_ctl();
	ecc_ctl_if ac_ctl();

	ecc_sync #(.W(PIN_W)) u_sync (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.din({frame_sync, line_bypass, acoustic_bypass, line_howl_detect_off_n,
			acoustic_howl_detect_off_n, noise_pad_low_bit, noise_pad_high_bit, line_atten_off,
			acoustic_atten_depth_n, line_gain_ctrl_off_n, acoustic_gain_ctrl_off_n,
			transmit_gain_pin}),
		.dout(pins_s)
	);

	function automatic logic signed [7:0] gain_db(input logic [5:0] c);
		logic signed [7:0] s;
		s = {{2{c[5]}}, c};
		if (s > GAIN_MAX_CODE)
			gain_db = GAIN_MAX_DB;
		else if (s < GAIN_MIN_CODE)
			gain_db = GAIN_MIN_DB;
		else
			gain_db = 8'(s * GAIN_STEP_DB);
	endfunction

	assign fs_s = pins_s[14];
	assign fs_rise = fs_s && !fs_prev_q;
	assign req = avs_read || avs_write;
	assign take = req && !avs_waitrequest;
	assign lane0 = avs_byteenable[0];

	// gain pins only ever add bits: the host grounds them to let the code alone rule
	assign tx_eff_d = tx_reg_q | {2'b00, pins_s[3:0]}; // RULE3
	always_comb
	begin
		line_eff_d = line_reg_q;
		line_eff_d[BIT_BYP] = line_reg_q[BIT_BYP] | pins_s[13]; // RULE4
		line_eff_d[BIT_HOWL] = line_reg_q[BIT_HOWL] | ~pins_s[11]; // RULE8 RULE15
		line_eff_d[BIT_PAD] = line_reg_q[BIT_PAD] | pins_s[9]; // RULE10
		line_eff_d[BIT_ATT] = line_reg_q[BIT_ATT] | pins_s[7]; // RULE11
		line_eff_d[BIT_GC] = line_reg_q[BIT_GC] | ~pins_s[5]; // RULE13 RULE15
		ac_eff_d = ac_reg_q;
		ac_eff_d[BIT_BYP] = ac_reg_q[BIT_BYP] | pins_s[12]; // RULE5
		ac_eff_d[BIT_HOWL] = ac_reg_q[BIT_HOWL] | ~pins_s[10]; // RULE8 RULE15
		ac_eff_d[BIT_PAD] = ac_reg_q[BIT_PAD] | pins_s[8]; // RULE10
		ac_eff_d[BIT_ATT] = ac_reg_q[BIT_ATT] | ~pins_s[6]; // RULE12 RULE15
		ac_eff_d[BIT_GC] = ac_reg_q[BIT_GC] | ~pins_s[4]; // RULE13 RULE15
	end

	// one wait cycle per access, so every transfer takes exactly two cycles
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			avs_waitrequest <= 1'b1;
		else
			avs_waitrequest <= !(req && avs_waitrequest);
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			tx_reg_q <= RST_TX;
			line_reg_q <= RST_CH;
			ac_reg_q <= RST_CH;
		end
		else if (take && avs_write && lane0)
		begin
			// reserved bits are not stored and read back as zero
			case (avs_address)
				ADDR_TX: tx_reg_q <= avs_writedata[5:0]; // RULE14
				ADDR_LINE: line_reg_q <= avs_writedata[7:0] & CH_MASK; // RULE14
				ADDR_AC: ac_reg_q <= avs_writedata[7:0] & CH_MASK; // RULE14
				default: ;
			endcase
		end
	end

	// counts the settle time the host owes after a write; reads as busy
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			hold_q <= '0;
		else if (take && avs_write && lane0 && avs_address != ADDR_STAT)
			hold_q <= 17'(HOLD_CYC); // RULE2
		else if (hold_q != '0)
			hold_q <= hold_q - 17'h00001;
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			avs_readdata <= '0;
		else if (avs_read && avs_waitrequest)
		begin
			case (avs_address)
				ADDR_TX: avs_readdata <= {26'h0, tx_reg_q};
				ADDR_LINE: avs_readdata <= {24'h0, line_reg_q};
				ADDR_AC: avs_readdata <= {24'h0, ac_reg_q};
				ADDR_STAT: avs_readdata <= {7'h0, hold_q != '0, ac_eff_q, line_eff_q, 2'b00,
					tx_eff_q};
				default: avs_readdata <= '0;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			fs_prev_q <= 1'b0;
			tx_eff_q <= RST_TX;
			line_eff_q <= RST_CH;
			ac_eff_q <= RST_CH;
		end
		else
		begin
			fs_prev_q <= fs_s;
			if (fs_rise)
			begin
				tx_eff_q <= tx_eff_d; // RULE2
				line_eff_q <= line_eff_d; // RULE2
				ac_eff_q <= ac_eff_d; // RULE2
			end
		end
	end

	assign pad_code = {ac_eff_q[BIT_PAD], line_eff_q[BIT_PAD]};
	assign pad_db = 5'(pad_code * PAD_STEP_DB);

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			tx_gain_db <= '0;
			tx_mute <= 1'b0;
			noise_output_gain <= '0;
			noise_input_loss <= '0;
		end
		else
		begin
			tx_mute <= tx_eff_q == CODE_MUTE; // RULE1
			tx_gain_db <= (tx_eff_q == CODE_MUTE) ? GAIN_MIN_DB : gain_db(tx_eff_q); // RULE1
			noise_output_gain <= pad_db; // RULE10
			noise_input_loss <= -$signed({1'b0, pad_db}); // RULE10
		end
	end

	assign line_ctl.bypass = line_eff_q[BIT_BYP];
	assign line_ctl.freeze = line_eff_q[BIT_FRZ];
	assign line_ctl.howl_off = line_eff_q[BIT_HOWL];
	assign line_ctl.clip = line_eff_q[BIT_CLIP];
	assign line_ctl.atten_off = line_eff_q[BIT_ATT];
	assign line_ctl.atten_deep = 1'b0;
	assign line_ctl.gc_off = line_eff_q[BIT_GC];
	assign line_ctl.rx_act = line_rx_active;
	assign line_ctl.tx_act = line_tx_active;
	// the acoustic attenuator has no off bit, only a deeper setting; acoustic bypass alone switches it off
	assign ac_ctl.bypass = ac_eff_q[BIT_BYP];
	assign ac_ctl.freeze = ac_eff_q[BIT_FRZ];
	assign ac_ctl.howl_off = ac_eff_q[BIT_HOWL];
	assign ac_ctl.clip = ac_eff_q[BIT_CLIP];
	assign ac_ctl.atten_off = 1'b0;
	assign ac_ctl.atten_deep = ac_eff_q[BIT_ATT];
	assign ac_ctl.gc_off = ac_eff_q[BIT_GC];
	assign ac_ctl.rx_act = ac_rx_active;
	assign ac_ctl.tx_act = ac_tx_active;
	assign ac_atten_db = ac_db;

	ecc_chan #(.W(SAMPLE_W), .THR(CLIP_THR)) u_line (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.ctl(line_ctl),
		.rx_in(line_receive_in),
		.tx_in(line_send_in),
		.core_rx(line_core_rx),
		.core_tx(line_core_tx),
		.rx_out(line_receive_out),
		.tx_out(line_send_out),
		.coef_freeze(line_coef_freeze),
		.howl_en(line_howl_en),
		.send_att(line_send_attenuator),
		.recv_att(line_receive_attenuator),
		.att_db(),
		.gc_en(line_input_gain_controller)
	);

	ecc_chan #(.W(SAMPLE_W), .THR(CLIP_THR)) u_ac (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.ctl(ac_ctl),
		.rx_in(acoustic_receive_in),
		.tx_in(acoustic_send_in),
		.core_rx(ac_core_rx),
		.core_tx(ac_core_tx),
		.rx_out(acoustic_receive_out),
		.tx_out(acoustic_send_out),
		.coef_freeze(acoustic_coef_freeze),
		.howl_en(ac_howl_en),
		.send_att(acoustic_send_attenuator),
		.recv_att(acoustic_receive_attenuator),
		.att_db(ac_db),
		.gc_en(acoustic_input_gain_controller)
	);

	property p_mute;
		@(posedge mclk) disable iff (sys_rst)
		tx_eff_q == CODE_MUTE |=> tx_mute && tx_gain_db == GAIN_MIN_DB;
	endproperty
	a_mute: assert property (p_mute) // RULE1
		else $error("mute code did not mute");

	property p_gain_step;
		@(posedge mclk) disable iff (sys_rst)
		tx_eff_q == 6'h3f |=> !tx_mute && tx_gain_db == -8'sh03;
	endproperty
	a_gain_step: assert property (p_gain_step) // RULE1
		else $error("code all ones did not give minus 3 dB");

	property p_latch;
		@(posedge mclk) disable iff (sys_rst)
		fs_rise |=> line_eff_q == $past(line_eff_d) && ac_eff_q == $past(ac_eff_d);
	endproperty
	a_latch: assert property (p_latch) // RULE2
		else $error("controls not latched on frame sync edge");

	property p_hold_between;
		@(posedge mclk) disable iff (sys_rst)
		!fs_rise |=> $stable(line_eff_q) && $stable(tx_eff_q);
	endproperty
	a_hold_between: assert property (p_hold_between) // RULE2
		else $error("controls changed between frame sync edges");

	property p_ac_bypass_pin;
		@(posedge mclk) disable iff (sys_rst)
		fs_rise && pins_s[12] |=> ac_eff_q[BIT_BYP] ##1 acoustic_coef_freeze;
	endproperty
	a_ac_bypass_pin: assert property (p_ac_bypass_pin) // RULE5
		else $error("acoustic bypass pin ignored");

	property p_bypass_off;
		@(posedge mclk) disable iff (sys_rst)
		line_eff_q[BIT_BYP] |=> !line_howl_en && !line_input_gain_controller &&
			!line_send_attenuator && !line_receive_attenuator && line_coef_freeze;
	endproperty
	a_bypass_off: assert property (p_bypass_off) // RULE6
		else $error("line functions active during bypass");

	property p_freeze;
		@(posedge mclk) disable iff (sys_rst)
		!ac_eff_q[BIT_BYP] |=> acoustic_coef_freeze == $past(ac_eff_q[BIT_FRZ]);
	endproperty
	a_freeze: assert property (p_freeze) // RULE7
		else $error("freeze bit not followed");

	property p_howl_pin;
		@(posedge mclk) disable iff (sys_rst)
		fs_rise && !pins_s[11] |=> line_eff_q[BIT_HOWL] ##1 !line_howl_en;
	endproperty
	a_howl_pin: assert property (p_howl_pin) // RULE8 RULE15
		else $error("howling pin low did not disable detector");

	property p_pad;
		@(posedge mclk) disable iff (sys_rst)
		pad_code == 2'b11 |=> noise_output_gain == 5'h12 && noise_input_loss == -6'sh12;
	endproperty
	a_pad: assert property (p_pad) // RULE10
		else $error("noise pad code 3 not 18 dB");

	property p_line_att;
		@(posedge mclk) disable iff (sys_rst)
		!line_eff_q[BIT_BYP] && !line_eff_q[BIT_ATT] && line_rx_active && !line_tx_active
			|=> line_send_attenuator && !line_receive_attenuator;
	endproperty
	a_line_att: assert property (p_line_att) // RULE11
		else $error("receive-only input did not attenuate send");

	property p_ac_depth;
		@(posedge mclk) disable iff (sys_rst)
		ac_eff_q[BIT_ATT] |=> ac_atten_db == ATT_DB_DEEP;
	endproperty
	a_ac_depth: assert property (p_ac_depth) // RULE12
		else $error("acoustic depth not 12 dB");

	property p_gc;
		@(posedge mclk) disable iff (sys_rst)
		!ac_eff_q[BIT_BYP] && !ac_eff_q[BIT_GC] |=> acoustic_input_gain_controller;
	endproperty
	a_gc: assert property (p_gc) // RULE13
		else $error("gain controller not enabled");

	c_write: cover property (@(posedge mclk) disable iff (sys_rst) take && avs_write);
	c_fs_bypass: cover property (@(posedge mclk) disable iff (sys_rst)
		fs_rise && line_eff_d[BIT_BYP]);
	c_mute: cover property (@(posedge mclk) disable iff (sys_rst) tx_mute);
endmodule

/* File: ecc_host.sv */
`timescale 1ns/1ps
module ecc_host (
	input wire logic mclk, // clock
	input wire logic avs_waitrequest, // slave stall
	input wire logic [31:0] avs_readdata, // read data
	output logic [3:0] avs_address, // byte address
	output logic avs_read, // read request
	output logic avs_write, // write request
	output logic [31:0] avs_writedata, // write data
	output logic [3:0] avs_byteenable, // byte lanes
	output logic [14:0] pin, // frame sync, gain pins, strap pins
	output logic hung // a bus wait ran out
);
	initial
	begin
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'h0;
		pin = 15'h038c;
		hung = 1'b0;
	end

	// waitrequest and read data are taken at the rising edge; the request stands until then
	task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] q);
		int i;
		@(posedge mclk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		avs_byteenable <= be;
		for (i = 0; i < 32; i++)
		begin
			@(posedge mclk);
			if (avs_waitrequest === 1'b0)
				break;
		end
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (i == 32)
			hung <= 1'b1;
	endtask

	task automatic straps(input logic [13:0] v);
		pin[13:0] <= v;
	endtask

	// straps settle before the pulse; nothing is rewritten until the pulse is long gone
	task automatic sync;
		repeat (4) @(posedge mclk);
		pin[14] <= 1'b1;
		repeat (8) @(posedge mclk);
		pin[14] <= 1'b0;
		repeat (8) @(posedge mclk);
	endtask
endmodule

/* File: ecc_regs_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
$display("BAD %s expected %0h seen %0h", nm, e, g); end end
module ecc_regs_tb;
	import ecc_pkg::*;
	logic mclk, sys_rst, avs_read, avs_write, avs_waitrequest, hung, frame_sync, tx_mute;
	logic [3:0] avs_address, avs_byteenable, transmit_gain_pin, ac_atten_db;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [14:0] pin;
	logic line_bypass, acoustic_bypass, line_howl_detect_off_n, acoustic_howl_detect_off_n;
	logic noise_pad_low_bit, noise_pad_high_bit, line_atten_off, acoustic_atten_depth_n;
	logic line_gain_ctrl_off_n, acoustic_gain_ctrl_off_n;
	logic line_rx_active, line_tx_active, ac_rx_active, ac_tx_active;
	logic [15:0] line_receive_in, line_send_in, acoustic_receive_in, acoustic_send_in;
	logic [15:0] line_core_rx, line_core_tx, ac_core_rx, ac_core_tx;
	logic [15:0] line_receive_out, line_send_out, acoustic_receive_out, acoustic_send_out;
	logic signed [7:0] tx_gain_db;
	logic signed [5:0] noise_input_loss;
	logic [4:0] noise_output_gain;
	logic line_coef_freeze, acoustic_coef_freeze, line_howl_en, ac_howl_en;
	logic line_send_attenuator, line_receive_attenuator, acoustic_send_attenuator;
	logic acoustic_receive_attenuator, line_input_gain_controller, acoustic_input_gain_controller;
	logic [7:0] le, ae, ple, pae;
	int n_errors, checks_done, c, g;

	assign {frame_sync, transmit_gain_pin, acoustic_gain_ctrl_off_n, line_gain_ctrl_off_n,
		acoustic_atten_depth_n, line_atten_off, noise_pad_high_bit, noise_pad_low_bit,
		acoustic_howl_detect_off_n, line_howl_detect_off_n, acoustic_bypass, line_bypass} = pin;

	ecc_regs #(.HOLD_CYC(8)) ecc_regs_i (.*);
	ecc_host ecc_host_i (.*);

	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	task automatic give_verdict;
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		ecc_host_i.bus(a, 1'b1, {24'h0, d}, 4'hf, rd);
	endtask

	task automatic rd_chk(input string nm, input logic [3:0] a, input logic [7:0] e);
		ecc_host_i.bus(a, 1'b0, 32'h0, 4'hf, rd);
		`CHK(nm, rd, {24'h0, e})
	endtask

	task automatic chk_ch(input string nm, input logic [7:0] e, input logic ac, input logic rx,
		input logic tx, input logic [15:0] si, ri, ct, cr, so, ro,
		input logic fz, hw, sa, ra, gc);
		logic on;
		on = !e[7] && (ac || !e[1]);
		`CHK({nm, " send"}, so, e[7] ? si : ((e[3] && ct <= CLIP_THRESH) ? CLIP_MIN : ct))
		`CHK({nm, " recv"}, ro, e[7] ? ri : cr)
		`CHK({nm, " freeze"}, fz, e[7] | e[5])
		`CHK({nm, " howl"}, hw, !e[7] && !e[4])
		`CHK({nm, " send att"}, sa, on && rx && !tx)
		`CHK({nm, " recv att"}, ra, on && tx)
		`CHK({nm, " gain ctrl"}, gc, !e[7] && !e[0])
	endtask

	// straps map to bits: active-low pins count when low
	task automatic run(input logic [7:0] lr, ar, input logic [13:0] sp, input logic [3:0] act);
		ple = le;
		pae = ae;
		le = lr | {sp[0], 2'b00, !sp[2], 1'b0, sp[4], sp[6], !sp[8]};
		ae = ar | {sp[1], 2'b00, !sp[3], 1'b0, sp[5], !sp[7], !sp[9]};
		wr(ADDR_LINE, lr);
		wr(ADDR_AC, ar);
		ecc_host_i.straps(sp);
		{ac_tx_active, ac_rx_active, line_tx_active, line_rx_active} <= act;
		ecc_host_i.bus(ADDR_STAT, 1'b0, 32'h0, 4'hf, rd);
		`CHK("status before sync", rd[23:8], {pae, ple})
		`CHK("busy before sync", rd[24], 1'b1)
		ecc_host_i.sync();
		ecc_host_i.bus(ADDR_STAT, 1'b0, 32'h0, 4'hf, rd);
		`CHK("status after sync", rd[23:8], {ae, le})
		`CHK("busy after sync", rd[24], 1'b0)
		chk_ch("line", le, 1'b0, act[0], act[1], line_send_in, line_receive_in, line_core_tx,
			line_core_rx, line_send_out, line_receive_out, line_coef_freeze, line_howl_en,
			line_send_attenuator, line_receive_attenuator, line_input_gain_controller);
		chk_ch("ac", ae, 1'b1, act[2], act[3], acoustic_send_in, acoustic_receive_in, ac_core_tx,
			ac_core_rx, acoustic_send_out, acoustic_receive_out, acoustic_coef_freeze, ac_howl_en,
			acoustic_send_attenuator, acoustic_receive_attenuator, acoustic_input_gain_controller);
		`CHK("pad gain", noise_output_gain, 5'(6 * {ae[2], le[2]}))
		`CHK("pad loss", noise_input_loss, 6'(-6 * {ae[2], le[2]}))
		if (!ae[7])
			`CHK("ac depth", ac_atten_db, ae[1] ? ATT_DB_DEEP : ATT_DB_SHALLOW)
	endtask

	initial
	begin
		n_errors = 0;
		checks_done = 0;
		le = 8'h00;
		ae = 8'h00;
		sys_rst = 1'b1;
		{ac_tx_active, ac_rx_active, line_tx_active, line_rx_active} = 4'h0;
		line_receive_in = 16'h1111;
		line_send_in = 16'h2222;
		acoustic_receive_in = 16'h3333;
		acoustic_send_in = 16'h4444;
		line_core_rx = 16'h5555;
		ac_core_rx = 16'h6666;
		// one core result sits on the clip threshold, the other just above it
		line_core_tx = 16'h0020;
		ac_core_tx = 16'h0021;
		repeat (4) @(posedge mclk);
		`CHK("wait in reset", avs_waitrequest, 1'b1)
		`CHK("depth in reset", ac_atten_db, ATT_DB_SHALLOW)
		repeat (4) @(posedge mclk);
		sys_rst <= 1'b0;
		rd_chk("tx reset", ADDR_TX, {2'b00, RST_TX});
		rd_chk("line reset", ADDR_LINE, RST_CH);
		rd_chk("ac reset", ADDR_AC, RST_CH);
		for (c = 0; c < 64; c++)
		begin
			wr(ADDR_TX, 8'(c));
			ecc_host_i.sync();
			g = 3 * int'($signed(c[5:0]));
			if (g > GAIN_MAX_DB)
				g = GAIN_MAX_DB;
			if (g < GAIN_MIN_DB || c == CODE_MUTE)
				g = GAIN_MIN_DB;
			`CHK("gain db", tx_gain_db, 8'(g))
			`CHK("mute", tx_mute, c == CODE_MUTE)
		end
		wr(ADDR_TX, 8'hff);
		rd_chk("tx reserved", ADDR_TX, 8'h3f);
		ecc_host_i.bus(ADDR_TX, 1'b1, 32'h15, 4'he, rd);
		rd_chk("tx lane off", ADDR_TX, 8'h3f);
		wr(ADDR_LINE, 8'hff);
		rd_chk("line reserved", ADDR_LINE, CH_MASK);
		run(8'h00, 8'h00, 14'h038c, 4'b0001);
		run(8'h80, 8'h00, 14'h038c, 4'b0011);
		run(8'h20, 8'h02, 14'h038c, 4'b0110);
		run(8'h10, 8'h08, 14'h038c, 4'b1000);
		run(8'h0b, 8'h05, 14'h038c, 4'b0101);
		run(8'h04, 8'h00, 14'h038c, 4'b1111);
		run(8'h00, 8'h00, 14'h03ba, 4'b1111);
		run(8'h00, 8'h00, 14'h004c, 4'b1010);
		run(8'hbf, 8'hbf, 14'h038c, 4'b1111);
		run(8'h00, 8'h00, 14'h038c, 4'b0000);
		give_verdict();
	end

	initial
	begin
		repeat (60000) @(posedge mclk);
		n_errors++;
		give_verdict();
	end

	always @(posedge hung)
	begin
		n_errors++;
		give_verdict();
	end
endmodule
